//--- hw/bridge_comp_regs.vh
// Register indices, field positions, reset values and format constants
// for the bridge front-end trim and polynomial compensation block.
// Assumes a Wishbone slave decoding word indices (byte address / 4).
//
// Behaviour
// RQ1 - First-stage gain code of 2 bits selects 3, 6, 9 or 12, code 0 at reset.
// RQ2 - Second-stage gain code of 4 bits selects 1.0 plus 0.4 per step, 0 at reset.
// RQ3 - Coarse offset is a 6-bit two's-complement code, zero at reset.
// RQ4 - Polarity bit inverts the sign of the offset-adjusted bridge input.
// RQ5 - Compensation sums all 15 terms in pressure and temperature up to degree 4.
// RQ6 - The programmer loads zero into coefficients of unused higher terms.
// RQ7 - Each coefficient is a 16-bit two's-complement word with 15 fraction bits.
// RQ8 - Constant term trims fine offset, linear pressure term fine sensitivity.
// RQ9 - The temperature operand comes from the internal temperature sensor.
// RQ10 - Pressure reads as Q15 at index 0x52, temperature as Q11 at index 0x62.
// RQ11 - Evaluation is wide fixed point and the result saturates, never wraps.
`ifndef BRIDGE_COMP_REGS_VH
`define BRIDGE_COMP_REGS_VH

// Word indices; byte address is four times the index
`define CTRL_IDX      8'h00
`define STATUS_IDX    8'h01
`define RESULT_IDX    8'h02
`define COEF_BASE_IDX 8'h10
`define COEF_LAST_IDX 8'h1e
`define PRESS_IDX     8'h52
`define TEMP_IDX      8'h62

// Control word fields
`define G1_LSB   0
`define G1_MSB   1
`define G2_LSB   2
`define G2_MSB   5
`define OFS_LSB  6
`define OFS_MSB  11
`define POL_BIT  12
`define CTRL_RST 13'h0000

// Format constants
`define COEF_COUNT 15
`define Q15_ONE    17'h08000
`define SAT_POS    16'h7fff
`define SAT_NEG    16'h8000

`endif

//--- hw/bridge_frontend_trim_and_poly_comp.v
// Trim decoding, sample FIFO and polynomial compensation engine.
// Assumes pressure samples and the temperature sensor output are
// synchronous to clk_i; software loads coefficients over Wishbone.
//
// The Wishbone slave port and the address map were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "bridge_comp_regs.vh"

module sample_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire             clk_i,
  input  wire             rst_i,
  input  wire             in_valid_i,
  output reg              in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  output reg              out_valid_o,
  input  wire             out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0]    wr_r;
  reg [AW-1:0]    rd_r;
  reg [AW:0]      count_r;
  wire            push = in_valid_i & in_ready_o;
  wire            pop  = out_valid_o & out_ready_i;
  wire [AW:0]     count_nxt = count_r + {{AW{1'b0}}, push}
                              - {{AW{1'b0}}, pop};

  assign out_data_o = mem_r[rd_r];

  // Flags are registered from the next count so both stay honest
  always @(posedge clk_i) begin
    if (rst_i) begin
      wr_r        <= {AW{1'b0}};
      rd_r        <= {AW{1'b0}};
      count_r     <= {(AW+1){1'b0}};
      in_ready_o  <= 1'b0;
      out_valid_o <= 1'b0;
    end else begin
      if (push) begin
        mem_r[wr_r] <= in_data_i;
        wr_r        <= (wr_r == DEPTH - 1) ? {AW{1'b0}} : wr_r + 1'b1;
      end
      if (pop)
        rd_r <= (rd_r == DEPTH - 1) ? {AW{1'b0}} : rd_r + 1'b1;
      count_r     <= count_nxt;
      in_ready_o  <= (count_nxt != DEPTH);
      out_valid_o <= (count_nxt != {(AW+1){1'b0}});
    end
  end
endmodule // sample_fifo

module bridge_frontend_trim_and_poly_comp #(
  parameter FIFO_DEPTH = 4,
  parameter FIFO_AW    = 2
) (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [9:2]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire [15:0] pressure_i,
  input  wire        pressure_valid_i,
  output wire        pressure_ready_o,
  input  wire [11:0] temp_i,
  output reg  [15:0] result_o,
  output reg         result_valid_o,
  input  wire        result_ready_i,
  output reg  [3:0]  first_stage_gain_o,
  output reg  [6:0]  second_stage_gain_x10_o,
  output reg  [5:0]  coarse_input_offset_o,
  output reg         polarity_o
);
  localparam S_IDLE = 2'd0;
  localparam S_POW  = 2'd1;
  localparam S_TERM = 2'd2;
  localparam S_OUT  = 2'd3;

  reg [12:0]        ctrl_r;
  reg [15:0]        coef_r [0:`COEF_COUNT-1];
  reg signed [16:0] ppow_r [0:4];
  reg signed [16:0] tpow_r [0:4];
  reg [15:0]        sensed_pressure_r;
  reg [11:0]        sensed_temperature_sample_r;
  reg [1:0]         state_r;
  reg [3:0]         step_r;
  reg signed [37:0] acc_r;
  reg [15:0]        last_result_r;
  integer           i;
  integer           j;

  wire        fifo_valid;
  wire [15:0] fifo_data;
  wire        fifo_pop = (state_r == S_IDLE) & fifo_valid;

  // Q15 product of two values in [-1, 1]; fits 17 bits without loss of sign
  function signed [16:0] qmul;
    input signed [16:0] a;
    input signed [16:0] b;
    reg signed [33:0] pr;
    begin
      pr   = a * b;
      qmul = pr[31:15];
    end
  endfunction

  // Pressure exponent of term k, in a00 a10 a01 a20 a11 a02 ... a04 order
  function [2:0] term_pe;
    input [3:0] k;
    begin
      case (k)
        4'd1, 4'd4, 4'd8, 4'd13: term_pe = 3'd1;
        4'd3, 4'd7, 4'd12:       term_pe = 3'd2;
        4'd6, 4'd11:             term_pe = 3'd3;
        4'd10:                   term_pe = 3'd4;
        default:                 term_pe = 3'd0;
      endcase
    end
  endfunction

  // Temperature exponent of term k in the same order
  function [2:0] term_te;
    input [3:0] k;
    begin
      case (k)
        4'd2, 4'd4, 4'd7, 4'd11: term_te = 3'd1;
        4'd5, 4'd8, 4'd12:       term_te = 3'd2;
        4'd9, 4'd13:             term_te = 3'd3;
        4'd14:                   term_te = 3'd4;
        default:                 term_te = 3'd0;
      endcase
    end
  endfunction

  // Byte-lane merge for Wishbone writes
  function [31:0] lane_merge;
    input [31:0] old;
    input [31:0] din;
    input [3:0]  sel;
    integer b;
    begin
      lane_merge = old;
      for (b = 0; b < 4; b = b + 1)
        if (sel[b])
          lane_merge[8*b +: 8] = din[8*b +: 8];
    end
  endfunction

  // Samples queue here so the converter can run ahead of the engine
  sample_fifo #(
    .WIDTH (16),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (pressure_valid_i),
    .in_ready_o  (pressure_ready_o),
    .in_data_i   (pressure_i),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_pop),
    .out_data_o  (fifo_data)
  );

  // Current term: monomial from the power tables, then coefficient product
  wire [3:0]        tk    = step_r;
  wire signed [16:0] mono = qmul(ppow_r[term_pe(tk)], tpow_r[term_te(tk)]);
  wire signed [15:0] coef = coef_r[tk];
  wire signed [33:0] term = coef * mono;
  wire signed [37:0] acc_nxt = acc_r + {{4{term[33]}}, term};
  wire signed [22:0] acc_q15 = acc_nxt[37:15];
  wire [15:0]        sat_q15 =
    (acc_q15 > 23'sd32767)  ? `SAT_POS :
    (acc_q15 < -23'sd32768) ? `SAT_NEG : acc_q15[15:0];

  // Compensation engine: powers first, then one term per cycle
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_r           <= S_IDLE;
      step_r            <= 4'd0;
      acc_r             <= 38'sd0;
      sensed_pressure_r <= 16'h0000;
      sensed_temperature_sample_r <= 12'h000;
      last_result_r     <= 16'h0000;
      result_o          <= 16'h0000;
      result_valid_o    <= 1'b0;
      for (i = 0; i < 5; i = i + 1) begin
        ppow_r[i] <= 17'sd0;
        tpow_r[i] <= 17'sd0;
      end
    end else begin
      case (state_r)
        S_IDLE: begin
          if (fifo_valid) begin
            sensed_pressure_r <= fifo_data;
            // RQ9 internal sensor temperature
            sensed_temperature_sample_r <= temp_i;
            ppow_r[0] <= `Q15_ONE;
            tpow_r[0] <= `Q15_ONE;
            ppow_r[1] <= {fifo_data[15], fifo_data};
            // RQ10 Q11 aligned to Q15
            tpow_r[1] <= {temp_i[11], temp_i, 4'h0};
            step_r    <= 4'd2;
            state_r   <= S_POW;
          end
        end
        S_POW: begin
          ppow_r[step_r[2:0]] <= qmul(ppow_r[step_r[2:0] - 3'd1], ppow_r[1]);
          tpow_r[step_r[2:0]] <= qmul(tpow_r[step_r[2:0] - 3'd1], tpow_r[1]);
          if (step_r == 4'd4) begin
            step_r  <= 4'd0;
            acc_r   <= 38'sd0;
            state_r <= S_TERM;
          end else begin
            step_r <= step_r + 4'd1;
          end
        end
        S_TERM: begin
          // RQ5 all fifteen terms summed
          // RQ8 term 0 offset, term 1 gain
          acc_r <= acc_nxt;
          if (step_r == `COEF_COUNT - 1) begin
            // RQ11 clamp instead of wrap
            result_o       <= sat_q15;
            last_result_r  <= sat_q15;
            result_valid_o <= 1'b1;
            state_r        <= S_OUT;
          end else begin
            step_r <= step_r + 4'd1;
          end
        end
        S_OUT: begin
          // Holds the engine so back-pressure reaches the FIFO
          if (result_ready_i) begin
            result_valid_o <= 1'b0;
            state_r        <= S_IDLE;
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // Front-end trim decode; the analog stages take these values
  always @(posedge clk_i) begin
    if (rst_i) begin
      first_stage_gain_o      <= 4'd3;
      second_stage_gain_x10_o <= 7'd10;
      coarse_input_offset_o   <= 6'h00;
      polarity_o              <= 1'b0;
    end else begin
      // RQ1 gain of 3 per code step
      first_stage_gain_o <= {2'b00, ctrl_r[`G1_MSB:`G1_LSB]} * 4'd3 + 4'd3;
      // RQ2 gain in tenths, 10 + 4n
      second_stage_gain_x10_o <=
        {1'b0, ctrl_r[`G2_MSB:`G2_LSB], 2'b00} + 7'd10;
      // RQ3 two's-complement offset code
      coarse_input_offset_o <= ctrl_r[`OFS_MSB:`OFS_LSB];
      // RQ4 sign flip before gain
      polarity_o <= ctrl_r[`POL_BIT];
    end
  end

  // Wishbone classic slave: one wait state, ack dropped after one cycle
  wire        wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire [7:0]  idx    = wb_adr_i;
  wire        is_coef = (idx >= `COEF_BASE_IDX) && (idx <= `COEF_LAST_IDX);
  wire [3:0]  coef_i = idx[3:0];
  wire [31:0] ctrl_m = lane_merge({19'h00000, ctrl_r}, wb_dat_i, wb_sel_i);
  wire [31:0] coef_m = lane_merge({16'h0000, coef_r[coef_i]}, wb_dat_i,
                                  wb_sel_i);

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      ctrl_r   <= `CTRL_RST;
      for (j = 0; j < `COEF_COUNT; j = j + 1)
        coef_r[j] <= 16'h0000;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && wb_we_i) begin
        if (idx == `CTRL_IDX)
          ctrl_r <= ctrl_m[12:0];
        // RQ7 coefficient word store
        if (is_coef)
          coef_r[coef_i] <= coef_m[15:0];
      end
      if (wb_req && !wb_we_i) begin
        if (is_coef)
          wb_dat_o <= {16'h0000, coef_r[coef_i]};
        else begin
          case (idx)
            `CTRL_IDX:   wb_dat_o <= {19'h00000, ctrl_r};
            `STATUS_IDX: wb_dat_o <= {29'h00000000, result_valid_o,
                                      fifo_valid, state_r != S_IDLE};
            `RESULT_IDX: wb_dat_o <= {16'h0000, last_result_r};
            // RQ10 operand readback
            `PRESS_IDX:  wb_dat_o <= {16'h0000, sensed_pressure_r};
            `TEMP_IDX:   wb_dat_o <= {20'h00000, sensed_temperature_sample_r};
            default:     wb_dat_o <= 32'h00000000;
          endcase
        end
      end
    end
  end
endmodule // bridge_frontend_trim_and_poly_comp
`default_nettype wire

//--- sim/bridge_comp_chk.sv
// Checker on the top-level ports of the bridge trim and compensation block.
// Assumes one clock domain with the synchronous active-high reset rst_i.
`timescale 1ns/100ps
`default_nettype none
module bridge_comp_chk (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [9:2]  wb_adr_i,
  input wire logic        wb_ack_o,
  input wire logic [15:0] result_o,
  input wire logic        result_valid_o,
  input wire logic        result_ready_i,
  input wire logic [3:0]  first_stage_gain_o,
  input wire logic [6:0]  second_stage_gain_x10_o,
  input wire logic [5:0]  coarse_input_offset_o,
  input wire logic        polarity_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Trim may follow a control write by one or two edges
  wire ctl_wr = wb_cyc_i & wb_stb_i & wb_we_i & (wb_adr_i == 8'h00);
  wire req    = wb_cyc_i & wb_stb_i & !wb_ack_o;
  g1_code_a: assert property (
    first_stage_gain_o inside {4'h3, 4'h6, 4'h9, 4'hc})
    else $error("first stage gain outside its set");
  g2_step_a: assert property (
    second_stage_gain_x10_o inside {[7'h0a:7'h46]} &&
    second_stage_gain_x10_o[1:0] == 2'h2)
    else $error("second stage gain off its grid");
  trim_rst_a: assert property (
    $past(rst_i) |-> first_stage_gain_o == 4'h3 &&
    second_stage_gain_x10_o == 7'h0a && coarse_input_offset_o == 6'h00)
    else $error("trim outputs not at reset value");
  ofs_hold_a: assert property (
    $changed(coarse_input_offset_o) |-> $past(ctl_wr) || $past(ctl_wr, 2))
    else $error("coarse offset moved without a write");
  pol_hold_a: assert property (
    $changed(polarity_o) |-> $past(ctl_wr) || $past(ctl_wr, 2))
    else $error("polarity moved without a write");
  ack_rsp_a: assert property (req |=> wb_ack_o)
    else $error("no ack one cycle after request");
  ack_one_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  res_hold_a: assert property (
    result_valid_o && !result_ready_i |=> result_valid_o && $stable(result_o))
    else $error("result dropped before it was taken");
  res_drop_a: assert property (
    result_valid_o && result_ready_i |=> !result_valid_o)
    else $error("result stayed after it was taken");
endmodule // bridge_comp_chk
bind bridge_frontend_trim_and_poly_comp bridge_comp_chk i_chk (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_ack_o,
  .result_o, .result_valid_o, .result_ready_i, .first_stage_gain_o,
  .second_stage_gain_x10_o, .coarse_input_offset_o, .polarity_o);
`default_nettype wire

//--- sim/bridge_model.sv
// Model of the bridge transducer path and the internal temperature sensor.
// Assumes the block takes a sample on an edge with valid and ready high.
`timescale 1ns/100ps
`default_nettype none
module bridge_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        send_i,
  input  wire logic [15:0] sample_i,
  input  wire logic [11:0] temp_code_i,
  input  wire logic        ready_i,
  output var  logic [15:0] pressure_o,
  output var  logic        valid_o,
  output wire logic [11:0] temp_o
);
  // Q15 sample hold
  // Once taken the bus shows the inverse, so a stale read cannot match
  always @(posedge clk_i) begin
    if (rst_i) begin
      valid_o <= 1'b0;
      pressure_o <= 16'h0000;
    end else if (valid_o && ready_i) begin
      valid_o <= 1'b0;
      pressure_o <= ~pressure_o;
    end else if (send_i && !valid_o) begin
      valid_o <= 1'b1;
      pressure_o <= sample_i;
    end
  end
  assign temp_o = temp_code_i;
endmodule // bridge_model
`default_nettype wire

//--- sim/bridge_frontend_trim_and_poly_comp_bench.sv
// Bench for the bridge trim and compensation block over Wishbone.
// Assumes the bridge model and the bound checker are compiled with it.
`timescale 1ns/100ps
`default_nettype none
module bridge_frontend_trim_and_poly_comp_bench;
  logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, send = 0;
  logic        rdy = 1, ack, pval, prdy, rval, pol;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'hf, g1;
  logic [31:0] dat = 32'h0, rd, dat_o;
  logic [15:0] smp = 16'h0, press, res;
  logic [11:0] tcode = 12'h200, temp;
  logic [6:0]  g2;
  logic [5:0]  ofs;
  int          num_errors = 0, comparisons = 0, i;
  // Case table: coefficient index, value, sample, expected result
  logic [7:0]  c_a [7] = '{8'h10, 8'h11, 8'h12, 8'h1e, 8'h13, 8'h10, 8'h10};
  logic [15:0] c_v [7] = '{16'h1000, 16'h4000, 16'h4000, 16'h4000,
                           16'hc000, 16'h7fff, 16'h8000};
  logic [15:0] c_p [7] = '{16'h2000, 16'h2000, 16'h2000, 16'h2000,
                           16'h2000, 16'h7fff, 16'hc000};
  logic [15:0] c_e [7] = '{16'h1000, 16'h2000, 16'h3000, 16'h3040,
                           16'h2c40, 16'h7fff, 16'h8000};
  always #20 clk_i = ~clk_i;
  bridge_frontend_trim_and_poly_comp #(.FIFO_DEPTH(4), .FIFO_AW(2)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .pressure_i(press),
    .pressure_valid_i(pval), .pressure_ready_o(prdy), .temp_i(temp),
    .result_o(res), .result_valid_o(rval), .result_ready_i(rdy),
    .first_stage_gain_o(g1), .second_stage_gain_x10_o(g2),
    .coarse_input_offset_o(ofs), .polarity_o(pol));
  bridge_model i_src (.clk_i(clk_i), .rst_i(rst_i), .send_i(send),
    .sample_i(smp), .temp_code_i(tcode), .ready_i(prdy),
    .pressure_o(press), .valid_o(pval), .temp_o(temp));
  task automatic chk(input string nm, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  // Classic cycle: hold everything until ack is sampled, then release
  // Byte lanes travel with the request; only the watchdog ends a wait
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s = 4'hf);
    @(posedge clk_i);
    {cyc, stb, we, adr, dat, sel} <= {1'b1, 1'b1, w, a, d, s};
    @(posedge clk_i);
    while (ack !== 1'b1)
      @(posedge clk_i);
    rd = dat_o;
    {cyc, stb} <= 2'b00;
  endtask
  // Hand one sample to the model and wait until the block takes it
  task automatic put(input logic [15:0] p);
    @(posedge clk_i);
    {send, smp} <= {1'b1, p};
    @(posedge clk_i);
    send <= 1'b0;
    @(posedge clk_i);
    while (pval === 1'b1)
      @(posedge clk_i);
  endtask
  // Result is compared at the edge where the block sees it taken
  task automatic get(input logic [15:0] e);
    @(posedge clk_i);
    while (!(rval === 1'b1 && rdy === 1'b1))
      @(posedge clk_i);
    chk("result", e, res);
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #400000;
    num_errors++;
    test_done;
  end
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, 8'h00, 0); chk("ctrl", 0, rd);
    wb(0, 8'h10, 0); chk("coef", 0, rd);
    wb(0, 8'h7f, 0); chk("unmapped", 0, rd);
    chk("first_stage_gain", 3, g1);
    chk("second_stage_gain", 10, g2);
    $display("test reset done");
    for (i = 0; i < 16; i++) begin
      wb(1, 0, (i % 2) << 12 | (i * 4 + 3) << 6 | i << 2 | i % 4);
      wb(0, 8'h00, 0);
      chk("first_stage_gain", 3 * (i % 4 + 1), g1);
      chk("second_stage_gain", 10 + 4 * i, g2);
      chk("offset", (i * 4 + 3) % 64, ofs);
      chk("polarity", i % 2, pol);
    end
    // Upper lane must keep its old bits, so a full-word write would show
    wb(1, 8'h00, 32'h0000003c, 4'h1);
    wb(0, 8'h00, 0); chk("lane", 32'h00001f3c, rd[12:0]);
    $display("test trim done");
    // Unused higher terms are cleared before any case is run
    for (i = 0; i < 15; i++)
      wb(1, 8'h10 + i, 0);
    for (i = 0; i < 7; i++) begin
      wb(1, c_a[i], c_v[i]);
      put(c_p[i]);
      get(c_e[i]);
    end
    wb(0, 8'h13, 0); chk("coef neg", 16'hc000, rd[15:0]);
    wb(0, 8'h52, 0); chk("pressure", 16'hc000, rd[15:0]);
    wb(0, 8'h62, 0); chk("temp", 12'h200, rd[11:0]);
    wb(0, 8'h02, 0); chk("last result", 16'h8000, rd[15:0]);
    $display("test poly done");
    rdy <= 1'b0;
    repeat (5) put(16'hc000);
    repeat (3) @(posedge clk_i);
    chk("fifo full", 0, prdy);
    // Engine holds its result, queue is full and the engine is busy
    wb(0, 8'h01, 0); chk("status", 3'h7, rd[2:0]);
    rdy <= 1'b1;
    repeat (5) get(16'h8000);
    $display("test fifo done");
    test_done;
  end
endmodule // bridge_frontend_trim_and_poly_comp_bench
`default_nettype wire
